// ==== ldcfg_top.sv ====
// How it works
// - Serial ports decode eight registers, base 0x100..0xFF8, eight-byte aligned, via 0x60/0x61.
// - Keyboard controller sits fixed at I/O 0x60 data and 0x64 command.
// - Game port decodes one register, base 0x100..0xFFF, byte aligned.
// - Config port relocatable 0x100..0xFFE, two-byte aligned; index then data.
// - Config port starts at 0x2E or 0x4E by strap; moved by 0x26/0x27.
// - Base decode compares address bits 11 to 0; the parallel port skips bit 10.
// - With oscillator bit 6 set, address bits 15 to 12 must be zero.
// - Index 0x70 bits 3:0 pick IRQ line; zero none; two shares SMI.
// - IRQ select resets to zero, except floppy device resets to six.
// - Routed IRQs are active-high; system management interrupt output active low.
// - Floppy IRQ and DMA pass only with its DMA gate bit set.
// - Parallel IRQ needs a non-zero line and its IRQ gate bit.
// - In extended mode parallel IRQ also needs service bit cleared.
// - UART IRQ needs line, any enable bit 0-3, and aux output two.
// - IRQ lines nobody selected stay undriven.
// - Index 0x74 bits 2:0 pick DMA 1..3; zero or 4..7 none.
// - DMA select resets to 2 for floppy and 4 for others.
// - Parallel DMA needs channel 1..3, extended mode and its DMA gate.
// - DMA channels nobody selected stay inactive, acknowledges ignored.
// - Activate and power bits are one linked bit; either sets device on.
// - Out-of-range base makes the device ignore host accesses.
// - Index 0x75 ignores writes and reads zero.
`timescale 1ns/10ps
module ldcfg_top
  import ldcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        soft_reset,
  input  wire logic        config_port_strap,
  // Host I/O cycles, already framed by the bus front end
  input  wire logic [15:0] io_addr,
  input  wire logic        io_write,
  input  wire logic        io_read,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_claim,
  // Per-device decode hits
  output logic             floppy_sel,
  output logic             parport_sel,
  output logic             uart1_sel,
  output logic             uart2_sel,
  output logic             keyb_sel,
  output logic             game_sel,
  // Device-side gate bits and requests
  input  wire logic        floppy_dma_gate,
  input  wire logic        floppy_irq_req,
  input  wire logic        floppy_dma_req,
  input  wire logic        parallel_irq_gate,
  input  wire logic        parallel_service_request_bit,
  input  wire logic        parallel_dma_gate,
  input  wire logic [2:0]  parallel_mode,
  input  wire logic        parport_irq_req,
  input  wire logic        parport_dma_req,
  input  wire logic [3:0]  uart1_irq_enables,
  input  wire logic        uart1_aux_output_two,
  input  wire logic        uart1_irq_req,
  input  wire logic [3:0]  uart2_irq_enables,
  input  wire logic        uart2_aux_output_two,
  input  wire logic        uart2_irq_req,
  input  wire logic        system_mgmt_event,
  // System lines
  output logic      [15:1] irq_level,
  output logic      [15:1] irq_oe,
  output logic             system_mgmt_irq_n,
  output logic      [3:1]  dma_req,
  input  wire logic [3:1]  dma_ack_n,
  output logic             floppy_dma_ack,
  output logic             parport_dma_ack
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    strap_state_e      sm;
    logic [1:0]        strap_sync;
    logic [1:0]        ack_sync_a;
    logic [2:0]        ack_meta;
    logic [2:0]        ack_sync_b;
    logic [11:0]       cfg_port;
    logic [7:0]        index;
    logic [3:0]        ldn;
    logic [7:0]        osc_cfg;
    logic [NUM_LD-1:0] active;
    logic [NUM_LD-1:0][15:0] base;
    logic [NUM_LD-1:0][7:0]  irq_route;
    logic [NUM_LD-1:0][7:0]  dma_route;
    logic [7:0]        rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // ---------------------------------------------------------------------------
  // Address decoders for relocatable devices
  // ---------------------------------------------------------------------------
  localparam int NDEC = 4;
  localparam logic [NDEC*4-1:0] DEC_LD = {LD_GAME, LD_UART2, LD_UART1, LD_FLOPPY};
  logic [NDEC-1:0] dec_hit;
  logic            cfg_hit;
  logic            cfg_idx_hit;
  logic            cfg_dat_hit;

  // The floppy window follows the serial ports' eight-byte rule, so one decoder type serves all four.
  genvar g;
  generate
    for (g = 0; g < NDEC; g++) begin : g_dec
      ldcfg_if dif ();
      localparam logic [3:0] LDX = DEC_LD[g*4 +: 4];
      assign dif.base        = st_reg.base[LDX][11:0];
      assign dif.align_mask  = (LDX == LD_GAME) ? 12'hFFF : UART_ALIGN_MASK;
      assign dif.max_base    = (LDX == LD_GAME) ? GAME_BASE_MAX : UART_BASE_MAX;
      assign dif.active      = st_reg.active[LDX];
      assign dif.full_decode = st_reg.osc_cfg[OSC_FULL_DECODE_BIT];
      assign dif.addr        = io_addr;
      window_decode u_dec (.d(dif.dec));
      assign dec_hit[g]      = dif.hit;
    end
  endgenerate

  // Parallel port decode: four-byte aligned window plus its high register group.
  logic par_hit;
  always_comb begin
    par_hit = st_reg.active[LD_PARPORT] &&
              (st_reg.base[LD_PARPORT][11:0] >= BASE_MIN) &&
              (st_reg.base[LD_PARPORT][11:0] <= 12'hFFC) &&
              (!st_reg.osc_cfg[OSC_FULL_DECODE_BIT] || io_addr[15:12] == 4'h0) &&
              (({io_addr[11], 1'b0, io_addr[9:2]}) == ({st_reg.base[LD_PARPORT][11], 1'b0,
                                                          st_reg.base[LD_PARPORT][9:2]}));
  end

  assign cfg_hit     = (!st_reg.osc_cfg[OSC_FULL_DECODE_BIT] || io_addr[15:12] == 4'h0) &&
                       ((io_addr[11:0] & CFG_ALIGN_MASK) == st_reg.cfg_port);
  assign cfg_idx_hit = cfg_hit && !io_addr[0];
  assign cfg_dat_hit = cfg_hit && io_addr[0];

  always_comb begin
    floppy_sel  = dec_hit[0];
    uart1_sel   = dec_hit[1];
    uart2_sel   = dec_hit[2];
    game_sel    = dec_hit[3];
    parport_sel = par_hit;
    keyb_sel    = st_reg.active[LD_KEYB] &&
                  (io_addr == KEYB_DATA_ADDR || io_addr == KEYB_CMD_ADDR);
    io_claim    = (io_read || io_write) &&
                  (cfg_hit || floppy_sel || uart1_sel || uart2_sel || game_sel || parport_sel || keyb_sel);
  end

  // ---------------------------------------------------------------------------
  // Configuration read mux
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] cfg_read(input state_s s);
    logic [7:0] v;
    v = 8'h00;
    unique case (s.index)
      IDX_LDN_SELECT:    v = {4'h0, s.ldn};
      IDX_CFG_PORT_LOW:  v = s.cfg_port[7:0];
      IDX_CFG_PORT_HIGH: v = {4'h0, s.cfg_port[11:8]};
      IDX_OSC_CONFIG:    v = s.osc_cfg;
      IDX_POWER_CONTROL: v = {7'h00, s.active[s.ldn]};
      IDX_ACTIVATE:      v = {7'h00, s.active[s.ldn]};
      IDX_BASE_HIGH:     v = s.base[s.ldn][15:8];
      IDX_BASE_LOW:      v = s.base[s.ldn][7:0];
      IDX_IRQ_ROUTE:     v = {4'h0, s.irq_route[s.ldn][3:0]};
      IDX_DMA_ROUTE:     v = {5'h00, s.dma_route[s.ldn][2:0]};
      IDX_DMA_ROUTE_TWO: v = 8'h00;
      default:           v = 8'h00;
    endcase
    // Device numbers from NUM_LD up read zero at every per-device index.
    if (s.ldn >= 4'(NUM_LD) &&
        s.index inside {IDX_POWER_CONTROL, IDX_ACTIVATE, IDX_BASE_HIGH,
                        IDX_BASE_LOW, IDX_IRQ_ROUTE, IDX_DMA_ROUTE}) begin
      v = 8'h00;
    end
    return v;
  endfunction

  function automatic logic [15:0] align_base(input logic [3:0] ld, input logic [15:0] b);
    logic [15:0] r;
    r = b;
    if (ld == LD_FLOPPY || ld == LD_UART1 || ld == LD_UART2) begin
      r = {b[15:3], 3'h0};
    end else if (ld == LD_PARPORT) begin
      r = {b[15:2], 2'h0};
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next            = st_reg;
    st_next.strap_sync = {st_reg.strap_sync[0], config_port_strap};
    st_next.ack_sync_a = st_reg.ack_sync_a;
    // Acknowledges follow the DMA controller's own timing, so two flops stand before any use.
    st_next.ack_meta   = dma_ack_n;
    st_next.ack_sync_b = st_reg.ack_meta;
    st_next.rdata      = st_reg.rdata;
    // The strap is sampled once, after it has passed the synchroniser.
    unique case (st_reg.sm)
      SM_IDLE: begin
        st_next.sm       = SM_STRAP;
        st_next.cfg_port = CFG_PORT_STRAP_LOW[11:0];
      end
      SM_STRAP: begin
        if (st_reg.ack_sync_a != 2'b11) begin
          st_next.ack_sync_a = {st_reg.ack_sync_a[0], 1'b1};
          if (st_reg.ack_sync_a == 2'b01) begin
            st_next.cfg_port = st_reg.strap_sync[1] ? CFG_PORT_STRAP_HIGH[11:0]
                                                    : CFG_PORT_STRAP_LOW[11:0];
          end
        end
      end
    endcase
    if (io_read && cfg_idx_hit) begin
      st_next.rdata = st_reg.index;
    end else if (io_read && cfg_dat_hit) begin
      st_next.rdata = cfg_read(st_reg);
    end
    if (io_write && cfg_idx_hit) begin
      st_next.index = io_wdata;
    end else if (io_write && cfg_dat_hit) begin
      unique case (st_reg.index)
        IDX_LDN_SELECT:    st_next.ldn = io_wdata[3:0];
        IDX_CFG_PORT_LOW:  st_next.cfg_port[7:0] = io_wdata & CFG_ALIGN_MASK[7:0];
        IDX_CFG_PORT_HIGH: st_next.cfg_port[11:8] = io_wdata[3:0];
        IDX_OSC_CONFIG:    st_next.osc_cfg = io_wdata;
        IDX_POWER_CONTROL: st_next.active[st_reg.ldn] = io_wdata[0];
        IDX_ACTIVATE:      st_next.active[st_reg.ldn] = io_wdata[0];
        IDX_BASE_HIGH:     st_next.base[st_reg.ldn] =
                             align_base(st_reg.ldn, {io_wdata, st_reg.base[st_reg.ldn][7:0]});
        IDX_BASE_LOW:      st_next.base[st_reg.ldn] =
                             align_base(st_reg.ldn, {st_reg.base[st_reg.ldn][15:8], io_wdata});
        IDX_IRQ_ROUTE:     st_next.irq_route[st_reg.ldn] = {4'h0, io_wdata[3:0]};
        IDX_DMA_ROUTE:     st_next.dma_route[st_reg.ldn] = {5'h00, io_wdata[2:0]};
        default:           st_next.index = st_reg.index;
      endcase
    end
    // Soft reset returns the routing registers and activation to defaults only.
    if (soft_reset) begin
      for (int i = 0; i < NUM_LD; i++) begin
        st_next.irq_route[i] = (i == 0) ? IRQ_ROUTE_RESET_FLOPPY : IRQ_ROUTE_RESET;
        st_next.dma_route[i] = (i == 0) ? DMA_ROUTE_RESET_FLOPPY : DMA_ROUTE_RESET_OTHER;
        st_next.active[i]    = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.cfg_port   <= CFG_PORT_STRAP_LOW[11:0];
      st_reg.ack_meta   <= 3'h7;
      st_reg.ack_sync_b <= 3'h7;
      st_reg.osc_cfg    <= OSC_CONFIG_RESET;
      for (int i = 0; i < NUM_LD; i++) begin
        st_reg.irq_route[i] <= (i == 0) ? IRQ_ROUTE_RESET_FLOPPY : IRQ_ROUTE_RESET;
        st_reg.dma_route[i] <= (i == 0) ? DMA_ROUTE_RESET_FLOPPY : DMA_ROUTE_RESET_OTHER;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign io_rdata = st_reg.rdata;

  // ---------------------------------------------------------------------------
  // Interrupt and DMA routing
  // ---------------------------------------------------------------------------
  localparam int NSRC = 4;
  logic [NSRC-1:0]      src_irq;
  logic [NSRC*4-1:0]    src_line;
  logic                 par_ecp;
  logic                 fl_dma_ok;
  logic                 pp_dma_ok;

  always_comb begin
    par_ecp   = (parallel_mode == ECP_MODE);
    src_line  = {st_reg.irq_route[LD_UART2][3:0], st_reg.irq_route[LD_UART1][3:0],
                 st_reg.irq_route[LD_PARPORT][3:0], st_reg.irq_route[LD_FLOPPY][3:0]};
    src_irq[0] = st_reg.active[LD_FLOPPY] && floppy_dma_gate && floppy_irq_req;
    src_irq[1] = st_reg.active[LD_PARPORT] && parallel_irq_gate && parport_irq_req &&
                 !(par_ecp && parallel_service_request_bit);
    src_irq[2] = st_reg.active[LD_UART1] && (|uart1_irq_enables) && uart1_aux_output_two &&
                 uart1_irq_req;
    src_irq[3] = st_reg.active[LD_UART2] && (|uart2_irq_enables) && uart2_aux_output_two &&
                 uart2_irq_req;
  end

  // Each line carries whichever selected source is asserting; any line 1..15 may be chosen.
  generate
    for (g = 1; g < 16; g++) begin : g_irq
      logic sel_any;
      logic lvl;
      always_comb begin
        sel_any = 1'b0;
        lvl     = 1'b0;
        for (int s = 0; s < NSRC; s++) begin
          if (src_line[s*4 +: 4] == 4'(g) && st_reg.active[(s == 0) ? 0 : s + 2]) begin
            sel_any = 1'b1;
            lvl     = lvl | src_irq[s];
          end
        end
      end
      assign irq_oe[g]    = sel_any;
      assign irq_level[g] = sel_any & lvl;
    end
  endgenerate

  // The management interrupt shares line 2; a device driving that line masks it.
  assign system_mgmt_irq_n = !(system_mgmt_event && !irq_oe[2]);

  always_comb begin
    fl_dma_ok = st_reg.active[LD_FLOPPY] && floppy_dma_gate &&
                (st_reg.dma_route[LD_FLOPPY][2:0] != 3'h0) &&
                (st_reg.dma_route[LD_FLOPPY][2:0] <= DMA_CHAN_MAX);
    pp_dma_ok = st_reg.active[LD_PARPORT] && par_ecp && parallel_dma_gate &&
                (st_reg.dma_route[LD_PARPORT][2:0] != 3'h0) &&
                (st_reg.dma_route[LD_PARPORT][2:0] <= DMA_CHAN_MAX);
    dma_req         = 3'h0;
    floppy_dma_ack  = 1'b0;
    parport_dma_ack = 1'b0;
    for (int c = 1; c <= 3; c++) begin
      if (fl_dma_ok && st_reg.dma_route[LD_FLOPPY][2:0] == 3'(c)) begin
        dma_req[c]     = dma_req[c] | floppy_dma_req;
        floppy_dma_ack = floppy_dma_ack | !st_reg.ack_sync_b[c-1];
      end
      if (pp_dma_ok && st_reg.dma_route[LD_PARPORT][2:0] == 3'(c)) begin
        dma_req[c]      = dma_req[c] | parport_dma_req;
        parport_dma_ack = parport_dma_ack | !st_reg.ack_sync_b[c-1];
      end
    end
  end

endmodule

// ==== ldcfg_pkg.sv ====
package ldcfg_pkg;

  // ---------------------------------------------------------------------------
  // Configuration port and index map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CFG_PORT_STRAP_LOW  = 16'h002E;
  localparam logic [15:0] CFG_PORT_STRAP_HIGH = 16'h004E;
  localparam logic [7:0]  IDX_CFG_PORT_LOW    = 8'h26;
  localparam logic [7:0]  IDX_CFG_PORT_HIGH   = 8'h27;
  localparam logic [7:0]  IDX_LDN_SELECT      = 8'h07;
  localparam logic [7:0]  IDX_SOFT_RESET      = 8'h02;
  localparam logic [7:0]  IDX_OSC_CONFIG      = 8'h24;
  localparam logic [7:0]  IDX_POWER_CONTROL   = 8'h22;
  localparam logic [7:0]  IDX_ACTIVATE        = 8'h30;
  localparam logic [7:0]  IDX_BASE_HIGH       = 8'h60;
  localparam logic [7:0]  IDX_BASE_LOW        = 8'h61;
  localparam logic [7:0]  IDX_IRQ_ROUTE       = 8'h70;
  localparam logic [7:0]  IDX_DMA_ROUTE       = 8'h74;
  localparam logic [7:0]  IDX_DMA_ROUTE_TWO   = 8'h75;
  localparam int          OSC_FULL_DECODE_BIT = 6;

  // ---------------------------------------------------------------------------
  // Logical devices
  // ---------------------------------------------------------------------------
  localparam int          NUM_LD     = 12;
  localparam logic [3:0]  LD_FLOPPY  = 4'h0;
  localparam logic [3:0]  LD_PARPORT = 4'h3;
  localparam logic [3:0]  LD_UART1   = 4'h4;
  localparam logic [3:0]  LD_UART2   = 4'h5;
  localparam logic [3:0]  LD_KEYB    = 4'h7;
  localparam logic [3:0]  LD_GAME    = 4'h9;

  // ---------------------------------------------------------------------------
  // Address windows
  // ---------------------------------------------------------------------------
  localparam logic [11:0] BASE_MIN        = 12'h100;
  localparam logic [11:0] UART_BASE_MAX   = 12'hFF8;
  localparam logic [11:0] GAME_BASE_MAX   = 12'hFFF;
  localparam logic [11:0] CFG_BASE_MAX    = 12'hFFE;
  localparam logic [11:0] UART_ALIGN_MASK = 12'hFF8;
  localparam logic [11:0] CFG_ALIGN_MASK  = 12'hFFE;
  localparam logic [15:0] KEYB_DATA_ADDR  = 16'h0060;
  localparam logic [15:0] KEYB_CMD_ADDR   = 16'h0064;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IRQ_ROUTE_RESET        = 8'h00;
  localparam logic [7:0]  IRQ_ROUTE_RESET_FLOPPY = 8'h06;
  localparam logic [7:0]  DMA_ROUTE_RESET_FLOPPY = 8'h02;
  localparam logic [7:0]  DMA_ROUTE_RESET_OTHER  = 8'h04;
  localparam logic [7:0]  OSC_CONFIG_RESET       = 8'h00;
  localparam logic [2:0]  ECP_MODE               = 3'h3;
  localparam logic [2:0]  DMA_CHAN_MAX           = 3'h3;

  typedef enum logic [0:0] {
    SM_IDLE   = 1'b0,
    SM_STRAP  = 1'b1
  } strap_state_e;

endpackage

// ==== ldcfg_if.sv ====
`timescale 1ns/10ps
interface ldcfg_if;
  import ldcfg_pkg::*;
  logic [11:0] base;
  logic [11:0] align_mask;
  logic [11:0] max_base;
  logic        active;
  logic        full_decode;
  logic [15:0] addr;
  logic        hit;
  modport cfg (output base, output align_mask, output max_base, output active,
               output full_decode, output addr, input hit);
  modport dec (input base, input align_mask, input max_base, input active,
               input full_decode, input addr, output hit);
endinterface

// ==== window_decode.sv ====
`timescale 1ns/10ps
module window_decode
  import ldcfg_pkg::*;
(
  ldcfg_if.dec d
);

  // Out-of-range bases never hit, so accesses to such a device are dropped.
  logic base_ok;
  logic upper_ok;

  always_comb begin
    base_ok  = (d.base >= BASE_MIN) && (d.base <= d.max_base);
    upper_ok = !d.full_decode || (d.addr[15:12] == 4'h0);
    d.hit    = d.active && base_ok && upper_ok &&
               ((d.addr[11:0] & d.align_mask) == (d.base & d.align_mask));
  end

endmodule

// ==== ldcfg_checker_assertions.sv ====
`timescale 1ns/10ps
module ldcfg_checker
  import ldcfg_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Watched ports
  input wire logic [15:0] io_addr,
  input wire logic        io_read,
  input wire logic [7:0]  io_rdata,
  input wire logic        keyb_sel,
  input wire logic        uart1_sel,
  input wire logic        game_sel,
  input wire logic [15:1] irq_level,
  input wire logic [15:1] irq_oe,
  input wire logic        system_mgmt_event,
  input wire logic        system_mgmt_irq_n,
  input wire logic        floppy_dma_gate,
  input wire logic        parallel_dma_gate,
  input wire logic [2:0]  parallel_mode,
  input wire logic [3:1]  dma_req,
  input wire logic        uart1_aux_output_two,
  input wire logic        uart2_aux_output_two,
  input wire logic        floppy_irq_req,
  input wire logic        parport_irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_smi_share: assert property (
    system_mgmt_irq_n == !(system_mgmt_event && !irq_oe[2])) else $error("smi output wrong");
  a_keyb_fixed: assert property (
    keyb_sel |-> io_addr[11:0] inside {12'h060, 12'h064}) else $error("keyboard hit off");
  a_level_owned: assert property (
    (irq_level & ~irq_oe) == 15'h0000) else $error("irq on undriven line");
  a_dma_gated: assert property (
    !floppy_dma_gate && !parallel_dma_gate |-> dma_req == 3'h0) else $error("dma without gate");
  a_dma_mode: assert property (
    parallel_mode != ECP_MODE && !floppy_dma_gate |-> dma_req == 3'h0) else $error("dma outside ecp");
  a_uart_aux: assert property (
    !(uart1_aux_output_two || uart2_aux_output_two || floppy_irq_req || parport_irq_req)
      |-> irq_level == 15'h0000) else $error("irq without aux");
  a_sel_range: assert property (
    uart1_sel || game_sel |-> io_addr[11:0] >= BASE_MIN) else $error("hit below range");
  a_rdata_hold: assert property (
    $changed(io_rdata) |-> $past(io_read)) else $error("read data moved");
endmodule

bind ldcfg_top ldcfg_checker chk (.*);

// ==== host_io.sv ====
`timescale 1ns/10ps
module host_io
  import ldcfg_pkg::*;
(
  // Bus
  input  wire logic        ref_clk,
  input  wire logic [7:0]  io_rdata,
  output logic      [15:0] io_addr,
  output logic             io_write,
  output logic             io_read,
  output logic      [7:0]  io_wdata
);
  logic [15:0] port_base;
  initial begin
    port_base = CFG_PORT_STRAP_LOW;
    io_addr = 16'hFFFF;
    io_write = 1'b0;
    io_read = 1'b0;
    io_wdata = 8'hFF;
  end
  // Released lines show the inverse so a stale value never looks valid.
  task automatic cycle(input logic [15:0] a, input logic wr, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_write = wr;
    io_read = !wr;
    @(negedge ref_clk);
    io_write = 1'b0;
    io_read = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    @(negedge ref_clk);
  endtask
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    cycle(port_base, 1'b1, idx);
    cycle(port_base + 16'h0001, 1'b1, d);
  endtask
  task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
    cycle(port_base, 1'b1, idx);
    cycle(port_base + 16'h0001, 1'b0, 8'hFF);
    @(negedge ref_clk);
    d = io_rdata;
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb
  import ldcfg_pkg::*;
;
  logic ref_clk, rst_n, soft_reset, config_port_strap, io_write, io_read, io_claim;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic floppy_sel, parport_sel, uart1_sel, uart2_sel, keyb_sel, game_sel;
  logic floppy_dma_gate, floppy_irq_req, floppy_dma_req, parallel_irq_gate;
  logic parallel_service_request_bit, parallel_dma_gate, parport_irq_req, parport_dma_req;
  logic [2:0] parallel_mode;
  logic [3:0] uart1_irq_enables, uart2_irq_enables;
  logic uart1_aux_output_two, uart1_irq_req, uart2_aux_output_two, uart2_irq_req;
  logic system_mgmt_event, system_mgmt_irq_n, floppy_dma_ack, parport_dma_ack;
  logic [15:1] irq_level, irq_oe;
  logic [3:1] dma_req, dma_ack_n;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] lds [3] = '{8'h00, 8'h03, 8'h05};

  ldcfg_top dut (.*);
  host_io host (.*);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    host.cfg_rd(idx, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask
  task automatic act(input logic [7:0] ldn, input logic [7:0] hi, input logic [7:0] lo);
    host.cfg_wr(IDX_LDN_SELECT, ldn);
    host.cfg_wr(IDX_BASE_HIGH, hi);
    host.cfg_wr(IDX_BASE_LOW, lo);
    host.cfg_wr(IDX_ACTIVATE, 8'h01);
  endtask
  task automatic probe(input logic [15:0] a, input logic [5:0] exp);
    host.io_addr = a;
    host.io_read = 1'b1;
    #10;
    chk({9'h0, io_claim, floppy_sel, parport_sel, uart1_sel, uart2_sel, keyb_sel, game_sel}, {9'h0, |exp, exp});
    @(negedge ref_clk);
    host.io_read = 1'b0;
    host.io_addr = ~a;
    @(negedge ref_clk);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    results();
  end

  initial begin
    {soft_reset, config_port_strap, floppy_dma_gate, floppy_irq_req, floppy_dma_req} = '0;
    {parallel_irq_gate, parallel_service_request_bit, parallel_dma_gate, parport_irq_req} = '0;
    {parport_dma_req, parallel_mode, uart1_irq_enables, uart2_irq_enables} = '0;
    {uart1_aux_output_two, uart1_irq_req, uart2_aux_output_two, uart2_irq_req} = '0;
    system_mgmt_event = 1'b0;
    dma_ack_n = 3'h7;
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int k = 0; k < 3; k++) begin
      host.cfg_wr(IDX_LDN_SELECT, lds[k]);
      rdc(IDX_IRQ_ROUTE, (k == 0) ? IRQ_ROUTE_RESET_FLOPPY : IRQ_ROUTE_RESET);
      rdc(IDX_DMA_ROUTE, (k == 0) ? DMA_ROUTE_RESET_FLOPPY : DMA_ROUTE_RESET_OTHER);
    end
    host.cfg_wr(IDX_DMA_ROUTE_TWO, 8'hFF);
    rdc(IDX_DMA_ROUTE_TWO, 8'h00);
    $display("reset values done");
    act(8'h04, 8'h03, 8'hFF);
    probe(16'h03F8, 6'b001000);
    probe(16'h03FF, 6'b001000);
    probe(16'h0400, 6'b000000);
    probe(16'h03F7, 6'b000000);
    probe(16'h13F8, 6'b001000);
    host.cfg_wr(IDX_OSC_CONFIG, 8'h40);
    probe(16'h13F8, 6'b000000);
    host.cfg_wr(IDX_OSC_CONFIG, OSC_CONFIG_RESET);
    host.cfg_wr(IDX_IRQ_ROUTE, 8'h04);
    uart1_irq_req = 1'b1;
    for (int g = 0; g < 4; g++) begin
      uart1_irq_enables = g[1] ? 4'h8 : 4'h0;
      uart1_aux_output_two = g[0];
      @(negedge ref_clk);
      chk({irq_level[4], irq_oe[4], irq_oe[3]}, {g == 3, 1'b1, 1'b0});
    end
    $display("serial port done");
    act(8'h05, 8'h00, 8'h80);
    probe(16'h0080, 6'b000000);
    act(8'h07, 8'h00, 8'h00);
    probe(16'h0060, 6'b000010);
    probe(16'h0064, 6'b000010);
    probe(16'h0062, 6'b000000);
    act(8'h09, 8'h02, 8'h01);
    probe(16'h0201, 6'b000001);
    probe(16'h0202, 6'b000000);
    $display("decode done");
    act(8'h00, 8'h03, 8'hF0);
    floppy_dma_req = 1'b1;
    floppy_irq_req = 1'b1;
    for (int g = 0; g < 2; g++) begin
      floppy_dma_gate = g[0];
      @(negedge ref_clk);
      chk({dma_req, irq_level[6]}, {1'b0, g[0], 1'b0, g[0]});
    end
    host.cfg_wr(IDX_DMA_ROUTE, 8'h05);
    chk({13'h0, dma_req}, 16'h0000);
    floppy_dma_gate = 1'b0;
    act(8'h03, 8'h03, 8'h78);
    host.cfg_wr(IDX_DMA_ROUTE, 8'h01);
    parport_dma_req = 1'b1;
    parallel_dma_gate = 1'b1;
    for (int m = 0; m < 4; m += 3) begin
      parallel_mode = m[2:0];
      @(negedge ref_clk);
      chk({13'h0, dma_req}, {15'h0, m[2:0] == ECP_MODE});
    end
    dma_ack_n = 3'h6;
    repeat (2) @(negedge ref_clk);
    chk({14'h0, floppy_dma_ack, parport_dma_ack}, 16'h0001);
    dma_ack_n = 3'h7;
    host.cfg_wr(IDX_IRQ_ROUTE, 8'h07);
    {parport_irq_req, parallel_irq_gate} = 2'b11;
    for (int s = 0; s < 4; s++) begin
      parallel_service_request_bit = s[0];
      parallel_mode = s[1] ? 3'h0 : ECP_MODE;
      @(negedge ref_clk);
      chk({15'h0, irq_level[7]}, {15'h0, s != 1});
    end
    parallel_irq_gate = 1'b0;
    @(negedge ref_clk);
    chk({15'h0, irq_level[7]}, 16'h0000);
    soft_reset = 1'b1;
    @(negedge ref_clk);
    soft_reset = 1'b0;
    @(negedge ref_clk);
    chk({13'h0, dma_req}, 16'h0000);
    host.cfg_wr(IDX_LDN_SELECT, 8'h00);
    rdc(IDX_DMA_ROUTE, DMA_ROUTE_RESET_FLOPPY);
    floppy_irq_req = 1'b0;
    $display("dma done");
    system_mgmt_event = 1'b1;
    @(negedge ref_clk);
    chk({15'h0, system_mgmt_irq_n}, 16'h0000);
    system_mgmt_event = 1'b0;
    host.cfg_wr(IDX_CFG_PORT_LOW, 8'h2E);
    host.cfg_wr(IDX_CFG_PORT_HIGH, 8'h03);
    host.port_base = 16'h032E;
    host.cfg_wr(IDX_LDN_SELECT, 8'h04);
    host.cfg_wr(IDX_IRQ_ROUTE, 8'h05);
    rdc(IDX_IRQ_ROUTE, 8'h05);
    host.cfg_wr(IDX_IRQ_ROUTE, 8'h02);
    host.cfg_wr(IDX_POWER_CONTROL, 8'h01);
    rdc(IDX_ACTIVATE, 8'h01);
    chk({13'h0, irq_level[2], irq_oe[2], system_mgmt_irq_n}, 16'h0007);
    $display("relocation done");
    config_port_strap = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    host.port_base = CFG_PORT_STRAP_HIGH;
    rdc(IDX_CFG_PORT_LOW, CFG_PORT_STRAP_HIGH[7:0]);
    $display("strap done");
    results();
  end
endmodule
